//--- hw/dds_map.svh
// offsets, field positions, reset values and counts of the diagnostic
// status word; definitions only, included by bare name
`ifndef DDS_MAP_SVH
`define DDS_MAP_SVH

`define DDS_ADDR_W          8
`define DDS_ADDR_STATUS     8'h6F
`define DDS_ADDR_IRQ_STAT   8'h80
`define DDS_ADDR_IRQ_CLR    8'h81
`define DDS_ADDR_IRQ_EN     8'h82

`define DDS_BIT_STST        31
`define DDS_BIT_OL_B        30
`define DDS_BIT_OL_A        29
`define DDS_BIT_SG_B        28
`define DDS_BIT_SG_A        27
`define DDS_BIT_OTPW        26
`define DDS_BIT_OT          25
`define DDS_BIT_STALL       24
`define DDS_CS_MSB          20
`define DDS_CS_LSB          16
`define DDS_BIT_FS          15
`define DDS_BIT_QUIET       14
`define DDS_BIT_SV_B        13
`define DDS_BIT_SV_A        12
`define DDS_LOAD_MSB        9
`define DDS_LOAD_LSB        0

`define DDS_IRQ_W           5
`define DDS_IRQ_SHORT       0
`define DDS_IRQ_OT          1
`define DDS_IRQ_OTPW        2
`define DDS_IRQ_STALL       3
`define DDS_IRQ_STST        4
`define DDS_IRQ_EN_RST      5'h00

`define DDS_STST_CLKS       1048576
`define DDS_OFF_TIME_SETTING_OFF        4'h0

`endif

//--- hw/dds_pkg.sv
// types shared by the diagnostic status word files
// assumes all diagnostic sources run on the system clock
package dds_pkg;

    // one cycle snapshot of the chopper and protection state
    typedef struct packed {
        logic       open_load_a;
        logic       open_load_b;
        logic       short_gnd_phase_a;
        logic       short_gnd_phase_b;
        logic       short_supply_phase_a;
        logic       short_supply_phase_b;
        logic       otpw_level;
        logic       ot_limit;
        logic       stall_detect;
        logic       fullstep_active;
        logic       quiet_chopper;
        logic [4:0] cur_scale;
        logic [9:0] load_measure_result;
        logic [9:0] coil_a_on_time;
    } dds_diag_in_t;

endpackage

//--- hw/dds_standstill.sv
// clocks-since-last-step counter giving the standstill level
// assumes a one cycle step pulse on the system clock
`timescale 1ns/100ps
module dds_standstill #(
    parameter int STST_CLKS = 1048576
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // step pulse in, standstill level out
    input  wire logic step_i,
    output logic      stst_o
);

    localparam int CW = $clog2(STST_CLKS + 1);
    localparam logic [CW-1:0] LIMIT = CW'(STST_CLKS);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // saturate so a long idle motor never wraps back to moving
    assign cnt_nxt = step_i ? '0
                   : (cnt_r == LIMIT) ? cnt_r : cnt_r + 1'b1;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_r  <= '0;
            stst_o <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            stst_o <= (cnt_nxt == LIMIT);
        end
    end

endmodule

//--- hw/dds_status.sv
// diagnostic status word of the stepper driver, its latched faults,
// the bridge enable and a small interrupt unit
// assumes diagnostic inputs and step pulse on clk_i; enable pin is async
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
`include "dds_map.svh"
module dds_status #(
    parameter int STST_CLKS = `DDS_STST_CLKS
) (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     srst_i,
    // register port
    input  wire logic [`DDS_ADDR_W-1:0]   addr_i,
    input  wire logic [31:0]              wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output logic      [31:0]              rdata_o,
    // diagnostic sources
    input  wire dds_pkg::dds_diag_in_t    diag_i,
    input  wire logic                     step_pulse_i,
    input  wire logic [3:0]               off_time_setting_i,
    input  wire logic                     enable_in_n_i,
    // driver control and interrupt
    output logic                          bridge_en_o,
    output logic                          irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // enable pin from outside the clock domain, and the standstill counter

    logic enn_s;
    logic stst_w;

    dds_sync3 #(
        .RST_VAL (1'b1)
    ) u_enn_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .pin_i   (enable_in_n_i),
        .level_o (enn_s)
    );

    dds_standstill #(
        .STST_CLKS (STST_CLKS)
    ) u_stst (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .step_i (step_pulse_i),
        .stst_o (stst_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // latched short and overtemp flags

    logic sgb_r;
    logic sga_r;
    logic svb_r;
    logic sva_r;
    logic ot_r;
    logic drv_off_w;
    logic sgb_nxt;
    logic sga_nxt;
    logic svb_nxt;
    logic sva_nxt;
    logic ot_nxt;

    assign drv_off_w = (off_time_setting_i == `DDS_OFF_TIME_SETTING_OFF) || enn_s;

    // clear only on disable
    // a fresh short wins over the disable clear so no event is lost
    assign sgb_nxt = diag_i.short_gnd_phase_b    | (sgb_r & ~drv_off_w);
    assign sga_nxt = diag_i.short_gnd_phase_a    | (sga_r & ~drv_off_w);
    assign svb_nxt = diag_i.short_supply_phase_b | (svb_r & ~drv_off_w);
    assign sva_nxt = diag_i.short_supply_phase_a | (sva_r & ~drv_off_w);

    assign ot_nxt = diag_i.ot_limit | (ot_r & diag_i.otpw_level);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sgb_r <= 1'b0;
            sga_r <= 1'b0;
            svb_r <= 1'b0;
            sva_r <= 1'b0;
            ot_r  <= 1'b0;
        end else begin
            sgb_r <= sgb_nxt;
            sga_r <= sga_nxt;
            svb_r <= svb_nxt;
            sva_r <= sva_nxt;
            ot_r  <= ot_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bridge enable

    logic short_any_w;
    logic bridge_nxt;

    assign short_any_w = sgb_r | sga_r | svb_r | sva_r;

    // overtemp disables bridges
    // open-load flags are left out on purpose: they are informative only
    assign bridge_nxt = ~short_any_w & ~ot_r & ~drv_off_w;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            bridge_en_o <= 1'b0;
        end else begin
            bridge_en_o <= bridge_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status word

    logic [31:0] status_r;
    logic [31:0] status_nxt;
    logic [9:0]  load_w;

    assign load_w = (stst_w && !diag_i.quiet_chopper)
                  ? diag_i.coil_a_on_time : diag_i.load_measure_result;

    always_comb begin
        status_nxt = 32'h0000_0000;
        status_nxt[`DDS_BIT_STST]  = stst_w;
        status_nxt[`DDS_BIT_OL_B]  = diag_i.open_load_b;
        status_nxt[`DDS_BIT_OL_A]  = diag_i.open_load_a;
        status_nxt[`DDS_BIT_SG_B]  = sgb_r;
        status_nxt[`DDS_BIT_SG_A]  = sga_r;
        status_nxt[`DDS_BIT_OTPW]  = diag_i.otpw_level;
        status_nxt[`DDS_BIT_OT]    = ot_r;
        status_nxt[`DDS_BIT_STALL] = diag_i.stall_detect;
        status_nxt[`DDS_CS_MSB:`DDS_CS_LSB] = diag_i.cur_scale;
        status_nxt[`DDS_BIT_FS]    = diag_i.fullstep_active;
        status_nxt[`DDS_BIT_QUIET] = diag_i.quiet_chopper;
        status_nxt[`DDS_BIT_SV_B]  = svb_r;
        status_nxt[`DDS_BIT_SV_A]  = sva_r;
        status_nxt[`DDS_LOAD_MSB:`DDS_LOAD_LSB] = load_w;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            status_r <= 32'h0000_0000;
        end else begin
            status_r <= status_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt unit

    logic [`DDS_IRQ_W-1:0] ev_prev_r;
    logic [`DDS_IRQ_W-1:0] ev_lvl_w;
    logic [`DDS_IRQ_W-1:0] ev_rise_w;
    logic [`DDS_IRQ_W-1:0] irq_stat_r;
    logic [`DDS_IRQ_W-1:0] irq_stat_nxt;
    logic [`DDS_IRQ_W-1:0] irq_en_r;
    logic [`DDS_IRQ_W-1:0] irq_clr_w;
    logic                  wr_clr_w;
    logic                  wr_en_w;

    assign ev_lvl_w[`DDS_IRQ_SHORT] = short_any_w;
    assign ev_lvl_w[`DDS_IRQ_OT]    = ot_r;
    assign ev_lvl_w[`DDS_IRQ_OTPW]  = diag_i.otpw_level;
    assign ev_lvl_w[`DDS_IRQ_STALL] = diag_i.stall_detect;
    assign ev_lvl_w[`DDS_IRQ_STST]  = stst_w;
    assign ev_rise_w = ev_lvl_w & ~ev_prev_r;

    assign wr_clr_w  = wr_i && (addr_i == `DDS_ADDR_IRQ_CLR);
    assign wr_en_w   = wr_i && (addr_i == `DDS_ADDR_IRQ_EN);
    assign irq_clr_w = wr_clr_w ? wdata_i[`DDS_IRQ_W-1:0] : '0;
    // set wins over a clear in the same cycle
    assign irq_stat_nxt = (irq_stat_r & ~irq_clr_w) | ev_rise_w;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ev_prev_r  <= '0;
            irq_stat_r <= '0;
            irq_en_r   <= `DDS_IRQ_EN_RST;
            irq_o      <= 1'b0;
        end else begin
            ev_prev_r  <= ev_lvl_w;
            irq_stat_r <= irq_stat_nxt;
            if (wr_en_w) begin
                irq_en_r <= wdata_i[`DDS_IRQ_W-1:0];
            end
            irq_o <= |(irq_stat_nxt & (wr_en_w
                     ? wdata_i[`DDS_IRQ_W-1:0] : irq_en_r));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    logic [31:0] rdata_nxt;

    // no side effects
    // writes to the status word decode to nothing; unmapped reads give zero
    assign rdata_nxt =
        !rd_i                           ? 32'h0000_0000 :
        (addr_i == `DDS_ADDR_STATUS)    ? status_r :
        (addr_i == `DDS_ADDR_IRQ_STAT)  ? {27'h0, irq_stat_r} :
        (addr_i == `DDS_ADDR_IRQ_EN)    ? {27'h0, irq_en_r} :
                                          32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_stst_drop: assert property (
        step_pulse_i |-> ##2 !status_r[`DDS_BIT_STST])
        else $error("standstill bit not cleared after step");

    a_olb_report: assert property (
        diag_i.open_load_b && !short_any_w && !ot_r && !drv_off_w
        |=> status_r[`DDS_BIT_OL_B] && bridge_en_o)
        else $error("open load B missing or disabled bridges");

    a_ola_report: assert property (
        diag_i.open_load_a |=> status_r[`DDS_BIT_OL_A])
        else $error("open load A not reported");

    a_sgb_trip: assert property (
        diag_i.short_gnd_phase_b
        |-> ##2 (status_r[`DDS_BIT_SG_B] && !bridge_en_o))
        else $error("short to ground B not latched");

    a_sga_trip: assert property (
        diag_i.short_gnd_phase_a
        |-> ##2 (status_r[`DDS_BIT_SG_A] && !bridge_en_o))
        else $error("short to ground A not latched");

    a_short_hold: assert property (
        (sgb_r || svb_r) && !drv_off_w
        |=> (sgb_r || svb_r) ##1 !bridge_en_o)
        else $error("short flag dropped while driver enabled");

    a_short_clear: assert property (
        sva_r && drv_off_w && !diag_i.short_supply_phase_a |=> !sva_r)
        else $error("short flag not cleared on disable");

    a_svb_trip: assert property (
        $rose(svb_r) |=> status_r[`DDS_BIT_SV_B])
        else $error("short to supply B not reported");

    a_ot_hold: assert property (
        ot_r && diag_i.otpw_level |=> ot_r ##1 !bridge_en_o)
        else $error("overtemp released while still warm");

    a_cs_mirror: assert property (
        ##1 status_r[`DDS_CS_MSB:`DDS_CS_LSB] == $past(diag_i.cur_scale))
        else $error("current scale not mirrored");

    a_load_mux: assert property (
        stst_w && !diag_i.quiet_chopper
        |=> status_r[9:0] == $past(diag_i.coil_a_on_time))
        else $error("on-time not shown at standstill");

    a_rsvd_zero: assert property (
        status_r[23:21] == 3'h0 && status_r[11:10] == 2'h0)
        else $error("reserved status bits not zero");

    a_read_back: assert property (
        rd_i && addr_i == `DDS_ADDR_STATUS
        |=> rdata_o == $past(status_r))
        else $error("status readback wrong");

    c_short_cycle: cover property (
        $rose(sgb_r) ##[1:20] $fell(sgb_r));
    c_standstill: cover property ($rose(status_r[`DDS_BIT_STST]));
    c_irq_fire: cover property ($rose(irq_o));

endmodule

//--- hw/dds_sync3.sv
// three stage pin synchroniser with agreement filter
// assumes an asynchronous level input and the system clock
`timescale 1ns/100ps
module dds_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // pin and filtered level
    input  wire logic pin_i,
    output logic      level_o
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    ////////////////////////////////////////////////////////////////////////
    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1_r    <= RST_VAL;
            s2_r    <= RST_VAL;
            s3_r    <= RST_VAL;
            level_o <= RST_VAL;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_o <= s3_r;
            end
        end
    end

endmodule

//--- verif/driver_diag_status_word_tb.sv
// self-checking bench of the diagnostic status word
// assumes dds_status on one clock, standstill count shortened to 32
`timescale 1ns/100ps
`include "dds_map.svh"
module driver_diag_status_word_tb;
    localparam int STST = 32;
    logic                  clk_i;
    logic                  srst_i;
    logic [7:0]            addr_i;
    logic [31:0]           wdata_i;
    logic                  wr_i;
    logic                  rd_i;
    logic [31:0]           rdata_o;
    dds_pkg::dds_diag_in_t diag_i;
    logic                  step_pulse_i;
    logic [3:0]            off_time_setting_i;
    logic                  enable_in_n_i;
    logic                  bridge_en_o;
    logic                  irq_o;
    logic [31:0]           exp_q[$];
    logic [31:0]           msk_q[$];
    logic [31:0]           me;
    logic [31:0]           mm;
    logic                  rd_seen;
    logic [63:0]           rnd;
    int                    n_mismatch;
    int                    checks_done;
    int                    sbit[4] = '{27, 28, 12, 13};

    dds_status #(.STST_CLKS(STST)) dut (
        .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .diag_i(diag_i), .step_pulse_i(step_pulse_i),
        .off_time_setting_i(off_time_setting_i),
        .enable_in_n_i(enable_in_n_i), .bridge_en_o(bridge_en_o),
        .irq_o(irq_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic finish_test();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // expectation noted here, compared by the watcher below
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask

    task automatic step();
        @(posedge clk_i);
        step_pulse_i <= 1'b1;
        @(posedge clk_i);
        step_pulse_i <= 1'b0;
    endtask

    task automatic bridge(input logic e);
        @(negedge clk_i);
        chk(bridge_en_o === e, "bridge enable level");
    endtask

    task automatic irq(input logic e);
        @(negedge clk_i);
        chk(irq_o === e, "interrupt level");
    endtask

    function automatic logic [31:0] exp_word(dds_pkg::dds_diag_in_t d,
                                             logic st);
        logic [31:0] w;
        w         = 32'h0;
        w[31]     = st;
        w[30]     = d.open_load_b;
        w[29]     = d.open_load_a;
        w[26]     = d.otpw_level;
        w[24]     = d.stall_detect;
        w[20:16]  = d.cur_scale;
        w[15]     = d.fullstep_active;
        w[14]     = d.quiet_chopper;
        w[9:0]    = (st && !d.quiet_chopper) ? d.coil_a_on_time
                                             : d.load_measure_result;
        return w;
    endfunction

    // read data stand only in the cycle after the strobe, else zero
    always @(posedge clk_i) begin
        if (rd_seen === 1'b1) begin
            me = exp_q.pop_front();
            mm = msk_q.pop_front();
            chk((rdata_o & mm) === me, "read data");
        end else if (srst_i === 1'b0) begin
            chk(rdata_o === 32'h0, "idle read data");
        end
        rd_seen <= rd_i;
    end

    initial begin
        repeat (6000) @(posedge clk_i);
        n_mismatch++;
        finish_test();
    end

    initial begin
        void'($urandom(32'hC914C20F));
        srst_i = 1'b1;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        rd_seen = 1'b0;
        diag_i = '0;
        step_pulse_i = 1'b0;
        off_time_setting_i = 4'h4;
        enable_in_n_i = 1'b0;
        n_mismatch = 0;
        checks_done = 0;
        cyc(2);
        srst_i <= 1'b0;
        rd(`DDS_ADDR_IRQ_EN, 32'h0, 32'hFFFFFFFF);
        cyc(10);
        for (int i = 0; i < 8; i++) begin
            rnd = {$urandom, $urandom};
            @(posedge clk_i) diag_i <= rnd[35:0] & 36'hC2FFFFFFF;
            step();
            cyc(2);
            wr(`DDS_ADDR_STATUS, rnd[63:32]);
            rd(`DDS_ADDR_STATUS, exp_word(diag_i, 1'b0), '1);
            bridge(1'b1);
        end
        @(posedge clk_i) diag_i.quiet_chopper <= 1'b0;
        cyc(STST + 4);
        rd(`DDS_ADDR_STATUS, exp_word(diag_i, 1'b1), '1);
        @(posedge clk_i) diag_i.quiet_chopper <= 1'b1;
        cyc(2);
        rd(`DDS_ADDR_STATUS, exp_word(diag_i, 1'b1), '1);
        step();
        cyc(2);
        rd(`DDS_ADDR_STATUS, exp_word(diag_i, 1'b0), '1);
        // short latches, cleared by off-time or enable pin
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i) diag_i[33-i] <= 1'b1;
            @(posedge clk_i) diag_i[33-i] <= 1'b0;
            cyc(3);
            bridge(1'b0);
            rd(`DDS_ADDR_STATUS, 32'h1 << sbit[i], 32'h1 << sbit[i]);
            cyc(5);
            rd(`DDS_ADDR_STATUS, 32'h1 << sbit[i], 32'h1 << sbit[i]);
            if (i % 2 == 1) begin
                enable_in_n_i <= 1'b1;
                cyc(10);
                enable_in_n_i <= 1'b0;
            end else begin
                off_time_setting_i <= `DDS_OFF_TIME_SETTING_OFF;
                cyc(3);
                off_time_setting_i <= 4'h4;
            end
            cyc(10);
            rd(`DDS_ADDR_STATUS, 32'h0, 32'h1 << sbit[i]);
            bridge(1'b1);
        end
        @(posedge clk_i) begin
            diag_i.otpw_level <= 1'b1;
            diag_i.ot_limit   <= 1'b1;
        end
        @(posedge clk_i) diag_i.ot_limit <= 1'b0;
        cyc(4);
        rd(`DDS_ADDR_STATUS, 32'h06000000, 32'h06000000);
        bridge(1'b0);
        @(posedge clk_i) diag_i.otpw_level <= 1'b0;
        cyc(4);
        rd(`DDS_ADDR_STATUS, 32'h0, 32'h06000000);
        bridge(1'b1);
        @(posedge clk_i) diag_i.stall_detect <= 1'b0;
        cyc(STST + 4);
        wr(`DDS_ADDR_IRQ_EN, 32'h8);
        rd(`DDS_ADDR_IRQ_EN, 32'h8, 32'h1F);
        wr(`DDS_ADDR_IRQ_CLR, 32'h1F);
        rd(`DDS_ADDR_IRQ_STAT, 32'h0, '1);
        irq(1'b0);
        @(posedge clk_i) diag_i.stall_detect <= 1'b1;
        cyc(3);
        irq(1'b1);
        rd(`DDS_ADDR_IRQ_STAT, 32'h8, '1);
        wr(`DDS_ADDR_IRQ_CLR, 32'h8);
        irq(1'b0);
        @(posedge clk_i) diag_i.stall_detect <= 1'b0;
        wr(`DDS_ADDR_IRQ_EN, 32'h0);
        @(posedge clk_i) diag_i.stall_detect <= 1'b1;
        cyc(3);
        irq(1'b0);
        rd(`DDS_ADDR_IRQ_STAT, 32'h8, '1);
        wr(`DDS_ADDR_IRQ_EN, 32'h8);
        irq(1'b1);
        wr(`DDS_ADDR_IRQ_CLR, 32'h8);
        irq(1'b0);
        // unmapped and write-only places read zero
        rd(8'h55, 32'h0, '1);
        rd(`DDS_ADDR_IRQ_CLR, 32'h0, '1);
        cyc(3);
        finish_test();
    end
endmodule
